// file: design/psq_pkg.sv
/*
 * Shared constants and types for the program sequencer block: bus register map,
 * instruction classes, mask-option codes and the sequencer state record.
 * Assumes a single clock domain and a 32-bit word-aligned register bus.
 */
`default_nettype none

package psq_pkg;

    localparam int ROM_DEPTH = 1024;
    localparam int PAGE_WORDS = 64;
    localparam int PAGE_COUNT = 16;

    // Instruction codes as decoded by the sequencer.
    localparam logic [7:0] OP_CLEAR_ACC   = 8'h00;
    localparam logic [7:0] OP_LOAD_Q_IND  = 8'hbf;
    localparam logic [7:0] OP_JUMP_IND    = 8'hff;
    localparam logic [7:0] OP_RETURN      = 8'h48;
    localparam logic [3:0] OP_LONG_JUMP   = 4'h6;
    localparam logic [1:0] CLS_JUMP_PAGE  = 2'h3;
    localparam logic [1:0] CLS_JUMP_SUB   = 2'h2;
    localparam logic [3:0] SUB_PAGE       = 4'h2;
    localparam logic [9:0] PC_RESET       = 10'h000;

    // Mask-option codes.
    localparam logic [3:0] OSC_IN_DIV16   = 4'h0;
    localparam logic [3:0] OSC_IN_DIV8    = 4'h1;
    localparam logic [3:0] OSC_IN_DIV32   = 4'h2;
    localparam logic [5:0] DIV_16         = 6'h10;
    localparam logic [5:0] DIV_8          = 6'h08;
    localparam logic [5:0] DIV_32         = 6'h20;
    localparam logic [3:0] TMR_SKIP_ONLY  = 4'h2;
    localparam logic [3:0] TMR_IDLE       = 4'h4;
    localparam logic [3:0] TMR_DUAL_RC    = 4'h6;
    localparam logic [3:0] TMR_DUAL_EXT   = 4'h7;
    localparam logic [3:0] FUNC_NORMAL    = 4'h0;
    localparam logic [3:0] FUNC_BUS       = 4'h1;
    localparam logic [3:0] OSC_OUT_DRIVE  = 4'h0;
    localparam logic [3:0] OSC_OUT_PULLUP = 4'h2;
    localparam logic [3:0] OSC_OUT_HIZ    = 4'h4;
    localparam logic [3:0] BOND_28        = 4'h0;
    localparam logic [3:0] BOND_24        = 4'h1;
    localparam logic [3:0] BOND_SHARED    = 4'h2;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL       = 8'h00;
    localparam logic [7:0] REG_STATUS     = 8'h04;
    localparam logic [7:0] REG_QDATA      = 8'h08;
    localparam logic [7:0] REG_ROM_ADDR   = 8'h0c;
    localparam logic [7:0] REG_ROM_DATA   = 8'h10;
    localparam logic [7:0] REG_OPTIONS    = 8'h14;

    // Field positions.
    localparam int CTRL_RUN_BIT   = 0;
    localparam int STAT_PC_LSB    = 0;
    localparam int STAT_STATE_LSB = 12;
    localparam int STAT_SKIP_BIT  = 16;
    localparam int STAT_TRAM_BIT  = 17;
    localparam int STAT_TROM_BIT  = 18;
    localparam int STAT_OSCIN_BIT = 19;
    localparam int STAT_RUN_BIT   = 20;
    localparam int OPT_OSCOUT_LSB = 0;
    localparam int OPT_OSCIN_LSB  = 4;
    localparam int OPT_TIMER_LSB  = 8;
    localparam int OPT_FUNC_LSB   = 12;
    localparam int OPT_BOND_LSB   = 16;

    // Read answers come on the third cycle of a held read.
    localparam logic [1:0] RD_CAPTURE = 2'h1;
    localparam logic [1:0] RD_LAST    = 2'h2;

    typedef enum logic [1:0] {ST_RUN, ST_SECOND, ST_IND} psq_state_t;

    typedef struct packed {
        psq_state_t  st;
        logic [9:0]  pc;
        logic [9:0]  sa;
        logic [9:0]  sb;
        logic [9:0]  sc;
        logic [9:0]  ind_base;
        logic [7:0]  first;
        logic [7:0]  instr;
        logic [7:0]  q;
        logic        skip_pend;
        logic        skipping;
        logic        is_load_q_indirect_instr;
        logic        exec;
        logic [4:0]  phase;
        logic        run;
        logic [9:0]  rom_ptr;
        logic [1:0]  rd_cnt;
        logic [31:0] rdata;
        logic        test_ram;
        logic        test_rom;
        logic        osc_drive;
    } psq_regs_t;

    localparam psq_regs_t REGS_RESET = '0;

endpackage
`default_nettype wire

// file: design/psq_rom.sv
/*
 * Program store of 1024 bytes with one shared port and a registered read.
 * Assumes the address is held steady while its data are wanted.
 */
`timescale 1ns/1ns
`default_nettype none

module psq_rom (
    input  wire logic       clock,
    input  wire logic       we,
    input  wire logic [9:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata_q
);
    import psq_pkg::*;

    logic [7:0] mem [0:ROM_DEPTH-1];

    always_ff @(posedge clock) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata_q <= mem[addr];
    end

endmodule // psq_rom
`default_nettype wire

// file: design/psq_sequencer.sv
/*
 * Program sequencer with fixed mask options: 10-bit counter over a paged
 * program store, skip timing, indirect fetches, test-mode entry and option
 * decode, with an Avalon-MM slave for loading and observing.
 * Assumes all inputs are synchronous to clock and that the core holds its
 * accumulator and memory nibbles steady through an indirect cycle.
 */
// The implementer's own choices: the Avalon-MM register port and the placing of the registers.
// Summary of operation
// R01: Program image starts with clear accumulator.
// R02: Skipped instructions cost one cycle per byte.
// R03: Indirect instructions take two cycles, one skipped.
// R04: Store holds sixteen pages of 64 words.
// R05: Ten-bit counter runs across page boundaries.
// R06: Last-word paged jumps target the following page.
// R07: Last-word indirects in group end use next group.
// R08: Serial pins select logic or store test mode.
// R09: Oscillator option picks divide by 16, 8, 32.
// R10: Timer option selects skip, idle, dual clock.
// R11: Function option selects normal or bus mode.
// R12: Reduced package needs general input options zero.
// R13: Reduced package drops inputs, interrupt, bus mode.
// R14: Oscillator output pin option picks drive or input.
// R15: Bonding option picks 28, 24 or shared.
// R16: Load q indirect pushes, loads q, then pops.
// R17: Mask options are fixed elaboration parameters.
`timescale 1ns/1ns
`default_nettype none

module psq_sequencer #(
    parameter logic [3:0] OSC_IN_OPT  = psq_pkg::OSC_IN_DIV16,
    parameter logic [3:0] TIMER_OPT   = psq_pkg::TMR_SKIP_ONLY,
    parameter logic [3:0] FUNC_OPT    = psq_pkg::FUNC_NORMAL,
    parameter logic [3:0] OSC_OUT_OPT = psq_pkg::OSC_OUT_DRIVE,
    parameter logic [3:0] BOND_OPT    = psq_pkg::BOND_28,
    parameter logic [3:0] GEN_IN_HIZ  = 4'h0
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic [3:0]  acc_in,
    input  wire logic [3:0]  ram_nibble_in,
    input  wire logic        skip_req,
    input  wire logic        so_pin_in,
    input  wire logic        si_pin_in,
    input  wire logic        osc_in_pin,
    input  wire logic        osc_out_pin_i,
    output logic             osc_out_pin_o,
    output logic             osc_out_pin_oe,
    output logic             osc_out_pullup,
    output logic [9:0]       pc_out,
    output logic [7:0]       instr_out,
    output logic             instr_exec,
    output logic             cycle_tick,
    output logic [7:0]       q_out,
    output logic             ram_logic_test,
    output logic             rom_test,
    output logic             skip_timer_en,
    output logic             idle_timer_en,
    output logic             dual_clock_en,
    output logic             dual_clock_ext,
    output logic             bus_mode_en,
    output logic             interrupt_avail,
    output logic             gen_inputs_avail,
    output logic [3:0]       gen_input_pullup,
    output logic             package_28,
    output logic             package_24
);
    import psq_pkg::*;

    function automatic logic [5:0] div_for(input logic [3:0] code);
        case (code)
            OSC_IN_DIV8:  div_for = DIV_8;
            OSC_IN_DIV32: div_for = DIV_32;
            default:      div_for = DIV_16;
        endcase
    endfunction

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    function automatic logic is_two_byte(input logic [7:0] b);
        is_two_byte = (b[7:4] == OP_LONG_JUMP);
    endfunction

    function automatic logic is_ind(input logic [7:0] b);
        is_ind = (b == OP_LOAD_Q_IND) || (b == OP_JUMP_IND);
    endfunction

    function automatic logic is_jp(input logic [7:0] b);
        is_jp = (b[7:6] == CLS_JUMP_PAGE) && (b != OP_JUMP_IND);
    endfunction

    function automatic logic is_jump_subroutine_page_instr(input logic [7:0] b);
        is_jump_subroutine_page_instr = (b[7:6] == CLS_JUMP_SUB) && (b != OP_LOAD_Q_IND);
    endfunction

    // The options are frozen with the program image; nothing at run time moves them.
    localparam logic [5:0] DIV_RATIO = div_for(OSC_IN_OPT); // see R09, R17
    localparam logic [4:0] DIV_LAST  = 5'(DIV_RATIO - 6'h01);
    localparam logic       REDUCED   = (BOND_OPT == BOND_24);

    psq_regs_t  r;
    psq_regs_t  n;
    logic [7:0] rom_rdata;
    logic [9:0] seq_addr;
    logic [9:0] rom_addr;
    logic       rom_we;
    logic       tick;
    logic       step;
    logic [9:0] base;
    logic [7:0] b;
    logic [31:0] rd_mux;

    // Indirect data come from the 256-word group that holds the counter of the next word.
    assign seq_addr = (r.st == ST_IND) ? {r.ind_base[9:8], acc_in, ram_nibble_in} : r.pc; // see R07
    assign rom_addr = r.run ? seq_addr : r.rom_ptr;
    assign rom_we   = avs_write && hit(avs_address, REG_ROM_DATA) && !r.run;

    // The store is 16 pages of 64 words, addressed flat by the 10-bit counter.
    psq_rom u_rom ( // see R04
        .clock   (clock),
        .we      (rom_we),
        .addr    (rom_addr),
        .wdata   (avs_writedata[7:0]),
        .rdata_q (rom_rdata)
    );

    assign tick = r.run && (r.phase == DIV_LAST);
    assign step = tick && !r.test_rom && !r.test_ram && !avs_write;
    assign base = r.pc + 10'h001; // see R05, R06
    assign b    = rom_rdata;

    always_comb begin
        rd_mux = '0;
        case (avs_address)
            REG_CTRL:     rd_mux[CTRL_RUN_BIT] = r.run;
            REG_STATUS: begin
                rd_mux[STAT_PC_LSB +: 10]   = r.pc;
                rd_mux[STAT_STATE_LSB +: 2] = r.st;
                rd_mux[STAT_SKIP_BIT]       = r.skip_pend;
                rd_mux[STAT_TRAM_BIT]       = r.test_ram;
                rd_mux[STAT_TROM_BIT]       = r.test_rom;
                rd_mux[STAT_OSCIN_BIT]      = osc_out_pin_i;
                rd_mux[STAT_RUN_BIT]        = r.run;
            end
            REG_QDATA:    rd_mux[7:0] = r.q;
            REG_ROM_ADDR: rd_mux[9:0] = r.rom_ptr;
            REG_ROM_DATA: rd_mux[7:0] = rom_rdata;
            REG_OPTIONS: begin
                rd_mux[OPT_OSCOUT_LSB +: 4] = OSC_OUT_OPT;
                rd_mux[OPT_OSCIN_LSB +: 4]  = OSC_IN_OPT;
                rd_mux[OPT_TIMER_LSB +: 4]  = TIMER_OPT;
                rd_mux[OPT_FUNC_LSB +: 4]   = FUNC_OPT;
                rd_mux[OPT_BOND_LSB +: 4]   = BOND_OPT;
            end
            default:      rd_mux = '0;
        endcase
    end

    always_comb begin
        n           = r;
        n.exec      = 1'b0;
        n.osc_drive = ~osc_in_pin;
        // Serial-output pin forced high selects a test mode by the serial input.
        n.test_ram  = so_pin_in & si_pin_in; // see R08
        n.test_rom  = so_pin_in & ~si_pin_in; // see R08
        n.phase     = tick ? 5'h00 : (r.run ? r.phase + 5'h01 : 5'h00); // see R09

        if (tick && r.test_rom) begin
            // Store dump: the counter walks and each byte is shown, none executed.
            n.pc    = base; // see R08
            n.instr = b;
        end else if (tick && !r.test_ram) begin
            case (r.st)
                ST_RUN: begin
                    n.pc = base;
                    if (r.skip_pend) begin
                        n.skip_pend = 1'b0;
                        if (is_two_byte(b)) begin
                            n.st       = ST_SECOND; // see R02
                            n.skipping = 1'b1;
                        end
                    end else begin
                        n.exec      = 1'b1;
                        n.instr     = b;
                        n.skip_pend = skip_req;
                        if (is_ind(b)) begin
                            n.st       = ST_IND; // see R03
                            n.ind_base = base; // see R06, R07
                            n.is_load_q_indirect_instr  = (b == OP_LOAD_Q_IND);
                            if (b == OP_LOAD_Q_IND) begin
                                n.sc = r.sb; // see R16
                                n.sb = r.sa;
                                n.sa = base;
                            end
                        end else if (is_two_byte(b)) begin
                            n.st       = ST_SECOND;
                            n.skipping = 1'b0;
                            n.first    = b;
                        end else if (is_jp(b)) begin
                            n.pc = {base[9:6], b[5:0]}; // see R06
                        end else if (is_jump_subroutine_page_instr(b)) begin
                            n.sc = r.sb;
                            n.sb = r.sa;
                            n.sa = base;
                            n.pc = {SUB_PAGE, b[5:0]};
                        end else if (b == OP_RETURN) begin
                            n.pc = r.sa;
                            n.sa = r.sb;
                            n.sb = r.sc;
                        end
                    end
                end
                ST_SECOND: begin
                    n.st = ST_RUN;
                    n.pc = r.skipping ? base : {r.first[1:0], b}; // see R02
                end
                ST_IND: begin
                    n.st = ST_RUN;
                    if (r.is_load_q_indirect_instr) begin
                        n.q  = b; // see R16
                        n.pc = r.sa;
                        n.sa = r.sb;
                        n.sb = r.sc;
                    end else begin
                        n.pc = {r.ind_base[9:8], b}; // see R07
                    end
                end
                default: n.st = ST_RUN;
            endcase
        end

        if (avs_write) begin
            case (avs_address)
                REG_CTRL: begin
                    n.run = avs_writedata[CTRL_RUN_BIT];
                    if (avs_writedata[CTRL_RUN_BIT] && !r.run) begin
                        // Start at word zero, which the image keeps as a clear.
                        n.pc        = PC_RESET; // see R01
                        n.st        = ST_RUN;
                        n.skip_pend = 1'b0;
                        n.phase     = 5'h00;
                    end
                end
                REG_ROM_ADDR: n.rom_ptr = avs_writedata[9:0];
                REG_ROM_DATA: n.rom_ptr = r.run ? r.rom_ptr : r.rom_ptr + 10'h001;
                default:      n.rom_ptr = r.rom_ptr;
            endcase
        end

        // Two wait cycles let the registered store read settle before capture.
        if (avs_read) begin
            n.rd_cnt = (r.rd_cnt == RD_LAST) ? 2'h0 : r.rd_cnt + 2'h1;
            if (r.rd_cnt == RD_CAPTURE) begin
                n.rdata = rd_mux;
            end
        end else begin
            n.rd_cnt = 2'h0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            r <= REGS_RESET;
        end else begin
            r <= n;
        end
    end

    assign avs_readdata    = r.rdata;
    assign avs_waitrequest = avs_read && (r.rd_cnt != RD_LAST);
    assign pc_out          = r.pc;
    assign instr_out       = r.instr;
    assign instr_exec      = r.exec;
    assign cycle_tick      = tick;
    assign q_out           = r.q;
    assign ram_logic_test  = r.test_ram;
    assign rom_test        = r.test_rom;

    // Oscillator output pin: driven, or an input with or without load.
    assign osc_out_pin_o  = r.osc_drive;
    assign osc_out_pin_oe = (OSC_OUT_OPT == OSC_OUT_DRIVE); // see R14
    assign osc_out_pullup = (OSC_OUT_OPT == OSC_OUT_PULLUP); // see R14

    assign skip_timer_en  = (TIMER_OPT == TMR_SKIP_ONLY); // see R10
    assign idle_timer_en  = (TIMER_OPT == TMR_IDLE) || dual_clock_en; // see R10
    assign dual_clock_en  = (TIMER_OPT == TMR_DUAL_RC) || (TIMER_OPT == TMR_DUAL_EXT); // see R10
    assign dual_clock_ext = (TIMER_OPT == TMR_DUAL_EXT);

    // The reduced package has no general inputs, so what hangs on them goes too.
    assign gen_inputs_avail = !REDUCED; // see R13
    assign interrupt_avail  = !REDUCED; // see R13
    assign bus_mode_en      = (FUNC_OPT == FUNC_BUS) && !REDUCED; // see R11, R13
    assign gen_input_pullup = REDUCED ? 4'h0 : ~GEN_IN_HIZ; // see R12, R13
    assign package_28       = (BOND_OPT == BOND_28) || (BOND_OPT == BOND_SHARED); // see R15
    assign package_24       = REDUCED || (BOND_OPT == BOND_SHARED); // see R15

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_skip_single: assert property ( // see R02
        step && r.st == ST_RUN && r.skip_pend && !is_two_byte(b)
        |=> !r.exec && r.st == ST_RUN && r.pc == $past(base))
        else $error("skipped one-byte instruction did not take one plain cycle");

    a_skip_pair: assert property ( // see R02
        step && r.st == ST_RUN && r.skip_pend && is_two_byte(b)
        |=> (r.st == ST_SECOND && r.skipping && !r.exec) [*8])
        else $error("skipped two-byte instruction did not spend a second cycle");

    a_ind_enter: assert property ( // see R03
        step && r.st == ST_RUN && !r.skip_pend && is_ind(b)
        |=> r.exec ##1 (r.st == ST_IND) [*7])
        else $error("indirect instruction did not take a second cycle");

    a_ind_leave: assert property ( // see R03
        step && r.st == ST_IND |=> r.st == ST_RUN && !r.exec)
        else $error("indirect second cycle lasted more than one cycle");

    a_pc_linear: assert property ( // see R05
        step && r.st == ST_RUN && !r.skip_pend && !is_ind(b) && !is_two_byte(b)
        && !is_jp(b) && !is_jump_subroutine_page_instr(b) && b != OP_RETURN
        |=> r.pc == 10'($past(r.pc) + 10'h001))
        else $error("counter did not step by one across the store");

    a_jp_page: assert property ( // see R06
        step && r.st == ST_RUN && !r.skip_pend && is_jp(b)
        |=> r.pc[9:6] == $past(base[9:6]) && r.pc[5:0] == $past(b[5:0]))
        else $error("paged jump took the wrong page");

    a_ind_group: assert property ( // see R07
        step && r.st == ST_RUN && !r.skip_pend && is_ind(b)
        |=> r.ind_base == $past(base) ##1 rom_addr[9:8] == r.ind_base[9:8])
        else $error("indirect fetch left the group of the next word");

    a_load_q_indirect_instr_load: assert property ( // see R16
        step && r.st == ST_IND && r.is_load_q_indirect_instr
        |=> q_out == $past(b) && r.pc == $past(r.sa) && r.sc == $past(r.sc))
        else $error("load q indirect did not load q and pop");

    a_test_quiet: assert property ( // see R08
        so_pin_in |=> (r.test_ram == $past(si_pin_in)) ##1 !r.exec)
        else $error("test mode entry or suppression failed");

    a_tick_period: assert property ( // see R09
        tick && !avs_write |=> !tick [*7])
        else $error("instruction cycle shorter than the smallest divide");

endmodule // psq_sequencer
`default_nettype wire

// file: sim/psq_far_end.sv
/* Far-side model: the program image and the manufacturing tester's serial pins.
   Assumes the bench copies the image into the store while the core is halted. */
`timescale 1ns/1ns
`default_nettype none
module psq_far_end (
    input  wire logic [1:0] test_sel,
    input  wire logic [9:0] img_addr,
    output logic      [7:0] img_byte,
    output logic            so_pin,
    output logic            si_pin
);
    // The tester forces serial output high and picks the mode with serial input.
    assign so_pin = test_sel[1];
    assign si_pin = test_sel[0];
    always_comb begin
        case (img_addr)
            10'h000: img_byte = 8'h00;
            10'h001: img_byte = 8'h60;
            10'h002: img_byte = 8'h3f;
            10'h03f: img_byte = 8'hc5;
            10'h045: img_byte = 8'h60;
            10'h046: img_byte = 8'hff;
            10'h0ff: img_byte = 8'hbf;
            10'h100: img_byte = 8'hff;
            // A fetch from the wrong page group lands on this decoy.
            10'h025: img_byte = 8'h33;
            10'h125: img_byte = 8'h5a;
            10'h15b: img_byte = 8'h61;
            10'h15e: img_byte = 8'hbf;
            default: img_byte = 8'h00;
        endcase
    end
endmodule // psq_far_end
`default_nettype wire

// file: sim/tb_top.sv
/* Bench for the program sequencer: loads a program over the register bus,
   traces execution, and checks options, test modes and reset.
   Assumes the far-side model supplies the image and the tester pins. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import psq_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;} psq_brow_t;
    typedef struct packed {logic [7:0] ins; logic [3:0] nt; logic [10:0] pc;} psq_xrow_t;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  avs_address = 8'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic        skip_req = 1'b0;
    logic        osc_in_pin = 1'b0;
    logic [1:0]  test_sel = 2'h0;
    logic [9:0]  img_addr = 10'h000;
    logic [7:0]  img_byte, instr_out, q_out;
    logic [31:0] avs_readdata, rd;
    logic [9:0]  pc_out;
    logic [3:0]  gen_input_pullup;
    logic avs_waitrequest, so_pin, si_pin, osc_out_pin_o, osc_out_pin_oe, osc_out_pullup;
    logic instr_exec, cycle_tick, ram_logic_test, rom_test, skip_timer_en, idle_timer_en;
    logic dual_clock_en, dual_clock_ext, bus_mode_en, interrupt_avail, gen_inputs_avail;
    logic package_28, package_24;
    logic        tick_b;
    logic [14:0] opt_b;
    int miscompares = 0, total_checks = 0, cycles = 0, tk = 99, nt, i;
    psq_brow_t brows [9] = '{
        '{1'b0, REG_OPTIONS, 32'h200}, '{1'b0, REG_ROM_ADDR, 32'h160},
        '{1'b1, REG_ROM_ADDR, 32'h125}, '{1'b0, REG_ROM_DATA, 32'h5a},
        '{1'b1, REG_ROM_ADDR, 32'h025}, '{1'b0, REG_ROM_DATA, 32'h33},
        '{1'b1, 8'h40, 32'hffffffff}, '{1'b0, 8'h40, 32'h0}, '{1'b0, REG_CTRL, 32'h0}};
    // Bit 10 of the counter column marks rows whose counter is not compared.
    psq_xrow_t xrows [9] = '{
        '{8'h00, 4'h1, 11'h001}, '{8'h60, 4'h1, 11'h400}, '{8'hc5, 4'h2, 11'h045},
        '{8'h60, 4'h1, 11'h400}, '{8'hbf, 4'h2, 11'h400}, '{8'hff, 4'h2, 11'h400},
        '{8'h00, 4'h2, 11'h15b}, '{8'h00, 4'h3, 11'h15e}, '{8'h00, 4'h2, 11'h160}};
    logic [3:0] trows [3] = '{4'b1110, 4'b1001, 4'b0100};

    psq_sequencer u_psq_sequencer (
        .clock, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .acc_in(4'h2), .ram_nibble_in(4'h5), .skip_req, .so_pin_in(so_pin),
        .si_pin_in(si_pin), .osc_in_pin, .osc_out_pin_i(1'b0), .osc_out_pin_o, .osc_out_pin_oe,
        .osc_out_pullup, .pc_out, .instr_out, .instr_exec, .cycle_tick, .q_out, .ram_logic_test,
        .rom_test, .skip_timer_en, .idle_timer_en, .dual_clock_en, .dual_clock_ext, .bus_mode_en,
        .interrupt_avail, .gen_inputs_avail, .gen_input_pullup, .package_28, .package_24
    );
    psq_far_end u_psq_far_end (.test_sel, .img_addr, .img_byte, .so_pin, .si_pin);
    // Reduced package: every general-input option stays zero.
    psq_sequencer #(.OSC_IN_OPT(OSC_IN_DIV8), .TIMER_OPT(TMR_DUAL_EXT), .FUNC_OPT(FUNC_BUS),
        .OSC_OUT_OPT(OSC_OUT_PULLUP), .BOND_OPT(BOND_24), .GEN_IN_HIZ(4'h0))
    u_psq_sequencer_b (
        .clock, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata(),
        .avs_waitrequest(), .acc_in(4'h2), .ram_nibble_in(4'h5), .skip_req, .so_pin_in(1'b0),
        .si_pin_in(1'b0), .osc_in_pin, .osc_out_pin_i(1'b0), .osc_out_pin_o(), .pc_out(),
        .instr_out(), .instr_exec(), .cycle_tick(tick_b), .q_out(), .ram_logic_test(),
        .rom_test(), .skip_timer_en(opt_b[14]), .idle_timer_en(opt_b[13]),
        .dual_clock_en(opt_b[12]), .dual_clock_ext(opt_b[11]), .bus_mode_en(opt_b[10]),
        .interrupt_avail(opt_b[9]), .gen_inputs_avail(opt_b[8]), .gen_input_pullup(opt_b[7:4]),
        .package_28(opt_b[3]), .package_24(opt_b[2]), .osc_out_pin_oe(opt_b[1]),
        .osc_out_pullup(opt_b[0])
    );

    always #50 clock = ~clock;

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // One gap clock follows each transfer so a strobe is never re-raised at its release.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clock);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            conclude();
        end
    end

    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        check("pc after reset", pc_out, 0);
        bus(1'b1, REG_ROM_ADDR, 32'h0, rd);
        for (i = 0; i < 352; i++) begin
            img_addr = i[9:0];
            @(posedge clock);
            bus(1'b1, REG_ROM_DATA, {24'h0, img_byte}, rd);
        end
        foreach (brows[k]) begin
            bus(brows[k].w, brows[k].a, brows[k].d, rd);
            if (!brows[k].w) check("register", rd, brows[k].d);
        end
        check("options", {skip_timer_en, idle_timer_en, dual_clock_en, dual_clock_ext,
              bus_mode_en, interrupt_avail, gen_inputs_avail, gen_input_pullup, package_28,
              package_24, osc_out_pin_oe, osc_out_pullup}, 15'b100001111111010);
        check("reduced options", opt_b, 15'b011100000000101);
        bus(1'b1, REG_CTRL, 32'h1, rd);
        // Skip is raised for the tick of the first and fourth cycle after the indirect jump.
        foreach (xrows[k]) begin
            nt = 0;
            do begin
                @(posedge clock);
                if (cycle_tick === 1'b1) begin
                    nt++;
                    tk++;
                end
                skip_req <= (tk == 1 || tk == 4);
            end while (instr_exec !== 1'b1);
            check("byte", instr_out, xrows[k].ins);
            check("cycles", nt, xrows[k].nt);
            if (!xrows[k].pc[10]) check("counter", pc_out, xrows[k].pc[9:0]);
            if (instr_out === 8'hff) tk = 0;
        end
        check("q", q_out, 8'h5a);
        for (i = 0; i < 2; i++) begin
            do @(posedge clock); while ((i ? tick_b : cycle_tick) !== 1'b1);
            nt = 0;
            do begin
                @(posedge clock);
                nt++;
            end while ((i ? tick_b : cycle_tick) !== 1'b1);
            check("clocks per cycle", nt, i ? DIV_8 : DIV_16);
        end
        bus(1'b1, REG_CTRL, 32'h0, rd);
        foreach (trows[k]) begin
            test_sel <= trows[k][3:2];
            repeat (3) @(posedge clock);
            check("test flags", {ram_logic_test, rom_test}, trows[k][1:0]);
        end
        test_sel <= 2'h3;
        bus(1'b1, REG_CTRL, 32'h1, rd);
        repeat (40) @(posedge clock);
        check("counter in logic test", pc_out, 0);
        test_sel <= 2'h0;
        repeat (40) @(posedge clock);
        check("counter runs", pc_out != 10'h000, 1'b1);
        osc_in_pin <= 1'b1;
        repeat (2) @(posedge clock);
        check("osc drive", osc_out_pin_o, 1'b0);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        check("counter in reset", pc_out, 0);
        check("q in reset", q_out, 0);
        rstn <= 1'b1;
        @(posedge clock);
        bus(1'b0, REG_CTRL, 32'h0, rd);
        check("run after reset", rd, 0);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
